// >>> power_format_defs.vh
// constants for the power mode and output format configuration block
`ifndef POWER_FORMAT_DEFS_VH
`define POWER_FORMAT_DEFS_VH

// register port offsets
`define RANGE_ACTIVE_CFG_ADDR 8'h15
`define POWER_FORMAT_CFG_ADDR 8'h16
`define RATE_DECIM_CFG_ADDR 8'h17
`define POWER_FORMAT_CFG_RESET 8'h00

// field positions inside power_format_cfg_reg
`define WAKE_PWR_HI 7
`define WAKE_PWR_LO 6
`define SLEEP_PWR_HI 5
`define SLEEP_PWR_LO 4
`define BYTE_ORDER_BIT 3
`define SPARE_BIT 2
`define TEMP_AINC_BIT 1
`define FAST_READ_BIT 0

// power mode encodings
`define PWR_LOW 2'h0
`define PWR_HIGH 2'h1

// output data address map
`define TEMP_OUT_ADDR 8'h01
`define OUT_X_ADDR 8'h04
`define OUT_Y_ADDR 8'h06
`define OUT_Z_ADDR 8'h08
`define VECTOR_MAGNITUDE_REG_ADDR 8'h0A
`define BUF_X_ADDR 8'h0C
`define BUF_Y_ADDR 8'h0E
`define BUF_Z_ADDR 8'h10
`define SAMPLE_LAST_ADDR 8'h11

// flexible mode base period, in tenths of a microsecond, and clock period
`define FLEX_BASE_US_X10 3125
`define CLK_PERIOD_NS 25
`define FLEX_BASE_CYCLES ((`FLEX_BASE_US_X10 * 100) / `CLK_PERIOD_NS)

`endif

// >>> flex_sample_timer.v
// sample period timer for flexible performance mode
`timescale 1ns/1ps
`include "power_format_defs.vh"

module flex_sample_timer #(
  parameter BASE_CYCLES = `FLEX_BASE_CYCLES
) (
  input wire clock,
  input wire rst,
  input wire clk_en,
  input wire run,
  input wire [11:0] idle_time,
  input wire [11:0] decim_factor,
  output reg sample_tick_q
);

  reg [15:0] base_q;
  reg [11:0] idle_q;
  reg [11:0] dec_q;
  wire base_end;
  wire idle_end;
  wire dec_end;
  wire [11:0] dec_last;

  // a decimation factor of zero is run as one
  assign dec_last = (decim_factor == 12'h000) ? 12'h000 : decim_factor - 12'h001;
  assign base_end = (base_q == BASE_CYCLES[15:0] - 16'h0001);
  assign idle_end = (idle_q == idle_time);
  assign dec_end = (dec_q >= dec_last);

  // nested counters: base unit, then idle+1 units, then decimation
  always @(posedge clock) begin
    if (rst) begin
      base_q <= 16'h0000;
      idle_q <= 12'h000;
      dec_q <= 12'h000;
      sample_tick_q <= 1'b0;
    end else if (clk_en) begin
      sample_tick_q <= 1'b0;
      if (!run) begin
        base_q <= 16'h0000;
        idle_q <= 12'h000;
        dec_q <= 12'h000;
      end else if (base_end) begin
        base_q <= 16'h0000;
        if (idle_end) begin
          idle_q <= 12'h000;
          if (dec_end) begin
            dec_q <= 12'h000;
            sample_tick_q <= 1'b1;
          end else begin
            dec_q <= dec_q + 12'h001;
          end
        end else begin
          idle_q <= idle_q + 12'h001;
        end
      end else begin
        base_q <= base_q + 16'h0001;
      end
    end
  end

endmodule // flex_sample_timer

// >>> power_format_cfg.v
// power mode and output format configuration register with read formatting
`timescale 1ns/1ps
`include "power_format_defs.vh"

module power_format_cfg #(
  parameter BASE_CYCLES = `FLEX_BASE_CYCLES
) (
  input wire clock,
  input wire rst,
  input wire clk_en,
  input wire [7:0] reg_addr,
  input wire reg_wr,
  input wire [7:0] reg_wdata,
  input wire reg_rd,
  output reg [7:0] reg_rdata_q,
  input wire [7:0] burst_addr,
  output reg [7:0] next_addr_q,
  input wire [7:0] ext_rdata,
  input wire [7:0] rate_decim_cfg_reg,
  input wire [11:0] wake_idle_time,
  input wire [11:0] sleep_idle_time,
  input wire [11:0] decim_factor,
  input wire in_sleep,
  input wire active,
  input wire [11:0] out_x,
  input wire [11:0] out_y,
  input wire [11:0] out_z,
  input wire [11:0] vector_magnitude_reg,
  input wire [11:0] buf_x,
  input wire [11:0] buf_y,
  input wire [11:0] buf_z,
  input wire [7:0] temp_out,
  output wire [1:0] wake_power_sel,
  output wire [1:0] sleep_power_sel,
  output reg [1:0] cur_power_sel_q,
  output reg [3:0] cur_rate_code_q,
  output reg [3:0] cur_decim_code_q,
  output reg cur_flexible_q,
  output wire byte_order_sel,
  output wire temp_autoinc_include,
  output wire fast_read,
  output wire sample_tick
);

  reg [7:0] power_format_cfg_reg_q;
  reg [7:0] fmt_byte;
  reg [7:0] read_d;
  reg [7:0] next_d;
  reg [11:0] sel_sample;
  reg in_sample;
  wire wake_flex;
  wire sleep_flex;
  wire cur_flex;
  wire [11:0] cur_idle;

  // rate code as seen by the rate tables; zero while the nibble means decimation
  function [3:0] rate_of;
    input flex;
    input [3:0] nib;
    begin
      rate_of = flex ? 4'h0 : nib;
    end
  endfunction

  // decimation code for flexible pacing; zero while the nibble means a rate
  function [3:0] decim_of;
    input flex;
    input [3:0] nib;
    begin
      decim_of = flex ? nib : 4'h0;
    end
  endfunction

  // flexible mode is any power selection with the top bit set
  function is_flex;
    input [1:0] pwr;
    begin
      is_flex = pwr[1];
    end
  endfunction

  // one byte of a 12 bit sample, by half and format
  function [7:0] sample_byte;
    input [11:0] smp;
    input upper_half;
    input big_end;
    input fast;
    begin
      if (fast)
        sample_byte = upper_half ? 8'h00 : smp[11:4];
      else if (big_end)
        sample_byte = upper_half ? {smp[3:0], 4'h0} : smp[11:4];
      else
        sample_byte = upper_half ? {4'h0, smp[11:8]} : smp[7:0];
    end
  endfunction

  // software write; bit 2 is stored and read back but steers nothing
  always @(posedge clock) begin
    if (rst) begin
      power_format_cfg_reg_q <= `POWER_FORMAT_CFG_RESET;
    end else if (clk_en && reg_wr && reg_addr == `POWER_FORMAT_CFG_ADDR) begin
      power_format_cfg_reg_q <= reg_wdata;
    end
  end

  // field outputs come straight from the register bits, so a write shows one cycle later
  // the power fields are not checked against the boot mode pin; keeping them low power is up to the host
  assign wake_power_sel = power_format_cfg_reg_q[`WAKE_PWR_HI:`WAKE_PWR_LO];
  assign sleep_power_sel = power_format_cfg_reg_q[`SLEEP_PWR_HI:`SLEEP_PWR_LO];
  assign byte_order_sel = power_format_cfg_reg_q[`BYTE_ORDER_BIT];
  assign temp_autoinc_include = power_format_cfg_reg_q[`TEMP_AINC_BIT];
  assign fast_read = power_format_cfg_reg_q[`FAST_READ_BIT];
  assign wake_flex = is_flex(wake_power_sel);
  assign sleep_flex = is_flex(sleep_power_sel);
  assign cur_flex = in_sleep ? sleep_flex : wake_flex;
  assign cur_idle = in_sleep ? sleep_idle_time : wake_idle_time;

  // nibble interpretation for the operating state in force
  // the rate register is sampled every enabled edge; the host only changes it in standby
  always @(posedge clock) begin
    if (rst) begin
      cur_power_sel_q <= `PWR_LOW;
      cur_rate_code_q <= 4'h0;
      cur_decim_code_q <= 4'h0;
      cur_flexible_q <= 1'b0;
    end else if (clk_en) begin
      cur_power_sel_q <= in_sleep ? sleep_power_sel : wake_power_sel;
      cur_flexible_q <= cur_flex;
      if (in_sleep) begin
        cur_rate_code_q <= rate_of(sleep_flex, rate_decim_cfg_reg[3:0]);
        cur_decim_code_q <= decim_of(sleep_flex, rate_decim_cfg_reg[3:0]);
      end else begin
        cur_rate_code_q <= rate_of(wake_flex, rate_decim_cfg_reg[7:4]);
        cur_decim_code_q <= decim_of(wake_flex, rate_decim_cfg_reg[7:4]);
      end
    end
  end

  // flexible mode pacing from idle time and decimation factor
  // the timer restarts whenever run drops; a wake/sleep switch with both modes flexible keeps run high and the partial period
  flex_sample_timer #(
    .BASE_CYCLES(BASE_CYCLES)
  ) u_timer (
    .clock(clock),
    .rst(rst),
    .clk_en(clk_en),
    .run(active && cur_flex),
    .idle_time(cur_idle),
    .decim_factor(decim_factor),
    .sample_tick_q(sample_tick)
  );

  // pick the sample that owns a formatted address
  always @* begin
    in_sample = 1'b1;
    sel_sample = 12'h000;
    case ({reg_addr[7:1], 1'b0})
      `OUT_X_ADDR: sel_sample = out_x;
      `OUT_Y_ADDR: sel_sample = out_y;
      `OUT_Z_ADDR: sel_sample = out_z;
      `VECTOR_MAGNITUDE_REG_ADDR: sel_sample = vector_magnitude_reg;
      `BUF_X_ADDR: sel_sample = buf_x;
      `BUF_Y_ADDR: sel_sample = buf_y;
      `BUF_Z_ADDR: sel_sample = buf_z;
      default: in_sample = 1'b0;
    endcase
    fmt_byte = sample_byte(sel_sample, reg_addr[0], byte_order_sel, fast_read);
  end

  // read data mux; non-sample fields pass through unformatted
  always @* begin
    if (reg_addr == `POWER_FORMAT_CFG_ADDR)
      read_d = power_format_cfg_reg_q;
    else if (in_sample)
      read_d = fmt_byte;
    else if (reg_addr == `TEMP_OUT_ADDR)
      read_d = temp_out;
    else
      read_d = ext_rdata;
  end

  // next burst address: fast read skips upper sample bytes, temp skip
  always @* begin
    next_d = burst_addr + 8'h01;
    if (fast_read && burst_addr >= `OUT_X_ADDR && burst_addr <= `SAMPLE_LAST_ADDR)
      next_d = {burst_addr[7:1], 1'b0} + 8'h02;
    else if (!temp_autoinc_include && next_d == `TEMP_OUT_ADDR)
      next_d = `TEMP_OUT_ADDR + 8'h01;
  end

  // registered answers to the register port
  // read data holds between reads so the serial side may shift it out at its own pace
  // the pointer answer is refreshed every enabled edge from the current pointer
  always @(posedge clock) begin
    if (rst) begin
      reg_rdata_q <= 8'h00;
      next_addr_q <= 8'h00;
    end else if (clk_en) begin
      if (reg_rd)
        reg_rdata_q <= read_d;
      next_addr_q <= next_d;
    end
  end

endmodule // power_format_cfg

// >>> power_format_cfg_checker.sv
// checker for the power mode and output format register
`timescale 1ns/1ps
module power_format_cfg_checker (
  input wire clock,
  input wire rst,
  input wire clk_en,
  input wire [7:0] reg_addr,
  input wire reg_wr,
  input wire [7:0] reg_wdata,
  input wire reg_rd,
  input wire [7:0] reg_rdata_q,
  input wire [7:0] burst_addr,
  input wire [7:0] next_addr_q,
  input wire [7:0] rate_decim_cfg_reg,
  input wire in_sleep,
  input wire [11:0] out_x,
  input wire [1:0] wake_power_sel,
  input wire [1:0] sleep_power_sel,
  input wire [3:0] cur_rate_code_q,
  input wire [3:0] cur_decim_code_q,
  input wire cur_flexible_q,
  input wire fast_read,
  input wire temp_autoinc_include
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // a write taken at the configuration address
  sequence cfg_wr_s;
    clk_en && reg_wr && reg_addr == 8'h16;
  endsequence
  // wake or sleep state with the mode field in low power or high performance
  sequence wake_fixed_s;
    clk_en && !in_sleep && !wake_power_sel[1];
  endsequence
  sequence sleep_fixed_s;
    clk_en && in_sleep && !sleep_power_sel[1];
  endsequence
  a_wake_field_write: assert property (cfg_wr_s |=> wake_power_sel == $past(reg_wdata[7:6]))
    else $error("wake mode field wrong");
  a_sleep_field_write: assert property (cfg_wr_s |=> sleep_power_sel == $past(reg_wdata[5:4]))
    else $error("sleep mode field wrong");
  a_wake_rate_code: assert property (wake_fixed_s |=> !cur_flexible_q && cur_rate_code_q == $past(rate_decim_cfg_reg[7:4]))
    else $error("wake rate code wrong");
  a_wake_decim_code: assert property ((clk_en && !in_sleep && wake_power_sel[1]) |=> cur_flexible_q
    && cur_decim_code_q == $past(rate_decim_cfg_reg[7:4]))
    else $error("wake decimation code wrong");
  a_sleep_rate_code: assert property (sleep_fixed_s |=> cur_rate_code_q == $past(rate_decim_cfg_reg[3:0]))
    else $error("sleep rate code wrong");
  a_sleep_decim_code: assert property ((clk_en && in_sleep && sleep_power_sel[1]) |=> cur_flexible_q
    && cur_decim_code_q == $past(rate_decim_cfg_reg[3:0]))
    else $error("sleep decimation code wrong");
  a_fast_top_byte: assert property ((clk_en && reg_rd && fast_read && reg_addr == 8'h04) |=> reg_rdata_q == $past(out_x[11:4]))
    else $error("fast read byte wrong");
  a_temp_skip_step: assert property ((clk_en && !temp_autoinc_include && burst_addr == 8'h00) |=> next_addr_q == 8'h02)
    else $error("temperature not skipped");
  a_fast_pointer_skip: assert property ((clk_en && fast_read && burst_addr == 8'h05) |=> next_addr_q == 8'h06)
    else $error("fast pointer step wrong");
endmodule // power_format_cfg_checker

bind power_format_cfg power_format_cfg_checker chk (.*);

// >>> host_port_model.sv
// host model driving the register port
`timescale 1ns/1ps
module host_port_model (
  input wire clock,
  input wire active,
  input wire [7:0] reg_rdata_q,
  output reg [7:0] reg_addr,
  output reg reg_wr,
  output reg [7:0] reg_wdata,
  output reg reg_rd,
  output reg [7:0] rate_decim_cfg_reg
);
  // idle bus at time zero
  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_wdata = 8'h00;
    reg_rd = 1'b0;
    rate_decim_cfg_reg = 8'h00;
  end
  // one write cycle, data line scrambled once released
  task wr(input [7:0] a, input [7:0] v);
    @(negedge clock);
    reg_addr = a;
    reg_wdata = v;
    reg_wr = 1'b1;
    @(negedge clock);
    reg_wr = 1'b0;
    reg_wdata = ~v;
  endtask
  // one read cycle, data taken one cycle after the strobe
  task rd(input [7:0] a, output [7:0] v);
    @(negedge clock);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clock);
    reg_rd = 1'b0;
    v = reg_rdata_q;
  endtask
  // rate settings change only in standby
  task set_rate(input [7:0] v);
    if (!active) rate_decim_cfg_reg = v;
  endtask
endmodule // host_port_model

// >>> power_format_cfg_tb_top.sv
// testbench for the power mode and output format register
`timescale 1ns/1ps
module power_format_cfg_tb_top;
  logic clock, rst, clk_en, in_sleep, active, reg_wr, reg_rd, fast_read, sample_tick;
  logic cur_flexible_q, byte_order_sel, temp_autoinc_include;
  logic [7:0] burst_addr, ext_rdata, temp_out, reg_addr, reg_wdata, reg_rdata_q, next_addr_q, rate_decim_cfg_reg, d;
  logic [11:0] wake_idle_time, sleep_idle_time, decim_factor, s;
  logic [1:0] wake_power_sel, sleep_power_sel, cur_power_sel_q;
  logic [3:0] cur_rate_code_q, cur_decim_code_q;
  int miscompares = 0;
  int total_checks = 0;
  power_format_cfg #(.BASE_CYCLES(4)) dut (.*, .out_x(s), .out_y(s), .out_z(s), .vector_magnitude_reg(s),
    .buf_x(s), .buf_y(s), .buf_z(s));
  host_port_model host (.*);
  always #12.5 clock = ~clock;
  task chk(input string n, input [11:0] e, input [11:0] g);
    total_checks++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected %0s expected %h seen %h", n, e, g);
    end
  endtask
  task rc(input [7:0] a, input [7:0] e);
    host.rd(a, d);
    chk("rdata", {4'h0, e}, {4'h0, d});
  endtask
  task tally_and_finish;
    if (miscompares == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task t_regs;
    rc(8'h16, 8'h00);
    host.wr(8'h16, 8'h04);
    host.wr(8'h15, 8'hFF);
    rc(8'h16, 8'h04);
    chk("fields", 12'h000, {wake_power_sel, sleep_power_sel, byte_order_sel, temp_autoinc_include, fast_read});
    rc(8'h20, 8'h5A);
  endtask
  task mode(input sl, input [1:0] pm, input [3:0] nib);
    @(negedge clock);
    in_sleep = sl;
    @(negedge clock);
    chk("power", {pm[1], pm}, {cur_flexible_q, cur_power_sel_q});
    chk("rate", pm[1] ? 12'h000 : nib, cur_rate_code_q);
    chk("decim", pm[1] ? nib : 12'h000, cur_decim_code_q);
  endtask
  task t_modes;
    host.set_rate(8'hA5);
    for (int m = 0; m < 16; m++) begin
      host.wr(8'h16, {m[3:0], 4'h0});
      mode(1'b0, m[3:2], 4'hA);
      mode(1'b1, m[1:0], 4'h5);
    end
  endtask
  task t_order;
    host.wr(8'h16, 8'h00);
    rc(8'h04, 8'hBC);
    rc(8'h0B, 8'h0A);
    host.wr(8'h16, 8'h08);
    rc(8'h10, 8'hAB);
    rc(8'h07, 8'hC0);
    rc(8'h01, 8'h3C);
    host.wr(8'h16, 8'h09);
    rc(8'h04, 8'hAB);
    rc(8'h0D, 8'h00);
  endtask
  task na(input [7:0] a, input [7:0] e);
    @(negedge clock);
    burst_addr = a;
    @(negedge clock);
    chk("next", e, next_addr_q);
  endtask
  task t_addr;
    na(8'h00, 8'h02);
    na(8'h05, 8'h06);
    na(8'h10, 8'h12);
    host.wr(8'h16, 8'h02);
    na(8'h00, 8'h01);
    na(8'h04, 8'h05);
  endtask
  task t_timer;
    int n;
    host.wr(8'h16, 8'h80);
    in_sleep = 1'b0;
    active = 1'b1;
    repeat (2) begin
      n = 0;
      @(negedge clock);
      while (sample_tick !== 1'b1 && n < 100) begin
        @(negedge clock);
        n++;
      end
    end
    chk("period", 12'h010, n[11:0] + 12'h001);
    active = 1'b0;
    host.wr(8'h16, 8'h00);
    chk("lowpower", 12'h000, {wake_power_sel, sleep_power_sel});
  endtask
  // stimulus at time zero, reset, then the scenarios
  initial begin
    clock = 1'b0;
    rst = 1'b1;
    clk_en = 1'b1;
    {in_sleep, active} = 2'h0;
    burst_addr = 8'h00;
    ext_rdata = 8'h5A;
    temp_out = 8'h3C;
    s = 12'hABC;
    wake_idle_time = 12'h001;
    sleep_idle_time = 12'h003;
    decim_factor = 12'h002;
    repeat (2) @(negedge clock);
    rst = 1'b0;
    t_regs;
    t_modes;
    t_order;
    t_addr;
    t_timer;
    tally_and_finish;
  end
  // watchdog against a hang
  initial begin
    #100000;
    miscompares++;
    tally_and_finish;
  end
endmodule // power_format_cfg_tb_top
